// ---- alu_core.sv ----
// Purpose: arithmetic/logic execution unit with I/O addressing, APB register access.
// Assumes: APB master per protocol; one command at a time.
// Notes:   pready is held low while a two-cycle operation finishes.
// Operation
// - add two registers, optionally plus carry; update Z C N V H; one cycle
// - subtract register from register, optionally with carry; Z C N V H; one cycle
// - subtract constant, optionally with carry; Z C N V H; one cycle
// - add constant to 16-bit pair; update Z C N V S; two cycles
// - subtract constant from 16-bit pair; update Z C N V S; two cycles
// - AND with register or constant; update Z N V only; one cycle
// - OR with register or constant, exclusive OR; update Z N V; one cycle
// - set bits ORs mask, clear bits ANDs with inverted mask; Z N V; one cycle
// - test ANDs register with itself, reporting zero or negative; one cycle
// - unsigned, signed, mixed multiplies give 16-bit product; Z and C; two cycles
// - fractional multiplies shift product left by one; Z and C; two cycles
// - low I/O range supports bit set, bit clear and bit-test skips
// - bit set and clear change only the named bit
// - some status flags clear when software writes one to them
// - I/O instructions use 0x00-0x3F; data-space accesses add 0x20
// - extended space 0x60-0xFF reachable only by load and store
module alu_core
   import alu_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr
);

   logic [7:0]     opa;
   logic [7:0]     opb;
   logic [7:0]     oph;
   logic [15:0]    result;
   alu_flags_t     sreg;
   alu_state_t     state;
   logic [15:0]    pend_res;
   alu_flags_t     pend_flags;
   logic [EVT_W-1:0] evt;

   logic           busy;
   logic           wr_done;
   logic           hit_opa;
   logic           hit_opb;
   logic           hit_oph;
   logic           hit_cmd;
   logic           hit_res;
   logic           hit_sreg;
   logic           hit_iocmd;
   logic           hit_iores;
   logic           hit_evt;
   logic           mapped;
   logic [31:0]    rd_mux;
   logic           next_pready;

   alu_op_t        op_in;
   logic           cin;
   logic [8:0]     sum9;
   logic [4:0]     hsum;
   logic [8:0]     dif9;
   logic [4:0]     hdif;
   logic [16:0]    wsum;
   logic [16:0]    wdif;
   logic           v_add;
   logic           v_sub;
   logic [7:0]     neg8;
   logic [7:0]     inc8;
   logic [7:0]     dec8;
   logic [15:0]    mul_p;
   logic           mul_c;
   logic [7:0]     r8;
   logic [15:0]    r16;
   alu_flags_t     nf;
   logic           two;
   logic           upd_nz8;
   logic           keep_z;

   alu_io_cmd_t    io_cmd;
   alu_io_res_t    io_res;
   logic           io_illegal;
   logic           io_start;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign busy      = (state == ST_SECOND);
   assign wr_done   = psel && penable && pready && pwrite && mapped;
   assign hit_opa   = (paddr == OFS_OPA);
   assign hit_opb   = (paddr == OFS_OPB);
   assign hit_oph   = (paddr == OFS_OPH);
   assign hit_cmd   = (paddr == OFS_CMD);
   assign hit_res   = (paddr == OFS_RES);
   assign hit_sreg  = (paddr == OFS_SREG);
   assign hit_iocmd = (paddr == OFS_IOCMD);
   assign hit_iores = (paddr == OFS_IORES);
   assign hit_evt   = (paddr == OFS_EVT);
   assign mapped    = hit_opa | hit_opb | hit_oph | hit_cmd | hit_res | hit_sreg
                    | hit_iocmd | hit_iores | hit_evt;
   assign rd_mux    = hit_opa   ? {24'h000000, opa}
                    : hit_opb   ? {24'h000000, opb}
                    : hit_oph   ? {24'h000000, oph}
                    : hit_res   ? {16'h0000, result}
                    : hit_sreg  ? {23'h000000, busy, 2'b00, sreg}
                    : hit_iores ? {8'h00, io_res.rdata, 5'h00, io_res.skip, io_res.legal, io_res.daddr}
                    : hit_evt   ? {{(32-EVT_W){1'b0}}, evt}
                    :             32'h00000000;
   // answer is held off while a two-cycle operation is still committing
   assign next_pready = psel && !pready && !busy;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= next_pready;
         prdata  <= next_pready && !pwrite ? rd_mux : 32'h00000000;
         pslverr <= next_pready && !mapped;
      end
   end

   // ------------------------------------------------------------
   // operation datapath
   // ------------------------------------------------------------
   assign op_in = alu_op_t'(pwdata[CMD_OP_LSB +: 5]);
   assign cin   = sreg.c && ((op_in == OP_ADD_WITH_CARRY) || (op_in == OP_SUBTRACT_WITH_CARRY)
                          || (op_in == OP_SUBTRACT_IMMEDIATE_WITH_CARRY));
   assign sum9  = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
   assign hsum  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
   assign dif9  = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
   assign hdif  = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
   assign wsum  = {1'b0, oph, opa} + {9'h000, opb};
   assign wdif  = {1'b0, oph, opa} - {9'h000, opb};
   assign v_add = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
   assign v_sub = (opa[7] != opb[7]) && (dif9[7] != opa[7]);
   assign neg8  = 8'h00 - opa;
   assign inc8  = opa + 8'h01;
   assign dec8  = opa - 8'h01;

   alu_mul u_mul (
      .a       (opa),
      .b       (opb),
      .op      (op_in),
      .product (mul_p),
      .carry   (mul_c)
   );

   always_comb
   begin
      r8      = 8'h00;
      r16     = 16'h0000;
      nf      = sreg;
      two     = 1'b0;
      upd_nz8 = 1'b1;
      keep_z  = 1'b0;
      unique case (op_in)
         OP_ADD, OP_ADD_WITH_CARRY:
         begin
            r8   = sum9[7:0];
            nf.c = sum9[8];
            nf.h = hsum[4];
            nf.v = v_add;
         end
         OP_SUBTRACT, OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_IMMEDIATE_WITH_CARRY:
         begin
            r8     = dif9[7:0];
            nf.c   = dif9[8];
            nf.h   = hdif[4];
            nf.v   = v_sub;
            // carry forms only keep zero set, so multi-byte compares chain
            keep_z = (op_in == OP_SUBTRACT_WITH_CARRY) || (op_in == OP_SUBTRACT_IMMEDIATE_WITH_CARRY);
         end
         OP_ADD_IMMEDIATE_WORD:
         begin
            upd_nz8 = 1'b0;
            two     = 1'b1;
            r16     = wsum[15:0];
            nf.v    = !oph[7] && wsum[15];
            nf.c    = oph[7] && !wsum[15];
            nf.n    = wsum[15];
            nf.z    = (wsum[15:0] == 16'h0000);
            nf.s    = wsum[15] ^ nf.v;
         end
         OP_SUBTRACT_IMMEDIATE_WORD:
         begin
            upd_nz8 = 1'b0;
            two     = 1'b1;
            r16     = wdif[15:0];
            nf.v    = oph[7] && !wdif[15];
            nf.c    = wdif[15] && !oph[7];
            nf.n    = wdif[15];
            nf.z    = (wdif[15:0] == 16'h0000);
            nf.s    = wdif[15] ^ nf.v;
         end
         OP_AND, OP_AND_WITH_CONSTANT:
         begin
            r8   = opa & opb;
            nf.v = 1'b0;
         end
         OP_OR, OP_OR_WITH_CONSTANT, OP_SET_BITS_IN_REGISTER:
         begin
            r8   = opa | opb;
            nf.v = 1'b0;
         end
         OP_EXCLUSIVE_OR_REGISTERS:
         begin
            r8   = opa ^ opb;
            nf.v = 1'b0;
         end
         OP_CLEAR_BITS_IN_REGISTER:
         begin
            r8   = opa & (ALL_ONES - opb);
            nf.v = 1'b0;
         end
         OP_TEST_ZERO_OR_MINUS:
         begin
            r8   = opa & opa;
            nf.v = 1'b0;
         end
         OP_ONES_COMPLEMENT:
         begin
            r8   = ALL_ONES - opa;
            nf.c = 1'b1;
            nf.v = 1'b0;
         end
         OP_TWOS_COMPLEMENT_NEGATE:
         begin
            r8   = neg8;
            nf.c = (neg8 != 8'h00);
            nf.v = (neg8 == BYTE_MIN_NEG);
            nf.h = neg8[3] | opa[3];
         end
         OP_INCREMENT:
         begin
            r8   = inc8;
            nf.v = (inc8 == BYTE_MIN_NEG);
         end
         OP_DECREMENT:
         begin
            r8   = dec8;
            nf.v = (dec8 == BYTE_MAX_POS);
         end
         OP_CLEAR_REGISTER:
         begin
            r8   = opa ^ opa;
            nf.v = 1'b0;
         end
         OP_SET_REGISTER_ALL_ONES:
         begin
            r8      = ALL_ONES;
            r16     = {8'h00, ALL_ONES};
            upd_nz8 = 1'b0;
         end
         OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED, OP_MULTIPLY_SIGNED_BY_UNSIGNED,
         OP_FRACTIONAL_MULTIPLY_UNSIGNED, OP_FRACTIONAL_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_MIXED:
         begin
            upd_nz8 = 1'b0;
            two     = 1'b1;
            r16     = mul_p;
            nf.c    = mul_c;
            nf.z    = (mul_p == 16'h0000);
         end
         default:
         begin
            upd_nz8 = 1'b0;
         end
      endcase
      if (upd_nz8)
      begin
         r16  = {8'h00, r8};
         nf.n = r8[7];
         nf.z = (r8 == 8'h00) && (!keep_z || sreg.z);
      end
   end

   // ------------------------------------------------------------
   // register file and commit
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         opa        <= 8'h00;
         opb        <= 8'h00;
         oph        <= 8'h00;
         result     <= 16'h0000;
         sreg       <= alu_flags_t'(SREG_RESET);
         state      <= ST_IDLE;
         pend_res   <= 16'h0000;
         pend_flags <= alu_flags_t'(SREG_RESET);
      end
      else
      begin
         if (wr_done && hit_opa)
         begin
            opa <= pwdata[7:0];
         end
         if (wr_done && hit_opb)
         begin
            opb <= pwdata[7:0];
         end
         if (wr_done && hit_oph)
         begin
            oph <= pwdata[7:0];
         end
         if (busy)
         begin
            result <= pend_res;
            sreg   <= pend_flags;
            state  <= ST_IDLE;
         end
         else if (wr_done && hit_cmd && two)
         begin
            pend_res   <= r16;
            pend_flags <= nf;
            state      <= ST_SECOND;
         end
         else if (wr_done && hit_cmd)
         begin
            result <= r16;
            sreg   <= nf;
         end
         else if (wr_done && hit_sreg)
         begin
            sreg <= alu_flags_t'(pwdata[5:0]);
         end
      end
   end

   // ------------------------------------------------------------
   // I/O addressing and event flags
   // ------------------------------------------------------------
   assign io_start    = wr_done && hit_iocmd;
   assign io_cmd.kind   = alu_io_kind_t'(pwdata[IOC_KIND_LSB +: 3]);
   assign io_cmd.bitsel = pwdata[IOC_BIT_LSB +: 3];
   assign io_cmd.addr   = pwdata[IOC_ADDR_LSB +: 8];
   assign io_cmd.data   = pwdata[IOC_DATA_LSB +: 8];

   alu_io u_io (
      .clk     (clk),
      .srst    (srst),
      .start   (io_start),
      .cmd     (io_cmd),
      .res     (io_res),
      .illegal (io_illegal)
   );

   // a new event in the clearing cycle still lands
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         evt <= '0;
      end
      else
      begin
         evt[EVT_ILLEGAL] <= (evt[EVT_ILLEGAL] && !(wr_done && hit_evt && pwdata[EVT_ILLEGAL]))
                          || io_illegal;
      end
   end

endmodule

// ---- alu_core_checker.sv ----
// Purpose: port-level timing checks of the execution unit
// Assumes: bound to alu_core, one clock domain
// Notes:   data values are judged by the bench
module alu_core_checker
   import alu_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // bus and timing assertions
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire logic done    = psel && penable && pready;
   wire logic cmd_wr  = done && pwrite && paddr == OFS_CMD;
   wire logic long_op = pwdata[4:0] inside {5'h06, 5'h07, [5'h16:5'h1b]};
   wire logic mapped  = paddr <= OFS_EVT && paddr[1:0] == 2'h0;
   wire logic setup   = psel && !penable;
   wire logic rd_done = done && !pwrite;
   chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   chk_ready_phase: assert property (pready |-> psel && penable) else $error("pready outside access");
   chk_err_decode: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
   chk_err_alone: assert property (pslverr |-> pready) else $error("pslverr alone");
   chk_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
   chk_cmd_reads: assert property (rd_done && paddr == OFS_CMD |-> prdata == 32'h0)
      else $error("cmd read not zero");
   chk_sreg_width: assert property (rd_done && paddr == OFS_SREG |-> prdata[31:9] == 23'h0)
      else $error("sreg high bits set");
   // one-cycle ops must not stall the next transfer
   chk_short_op: assert property (cmd_wr && !long_op ##1 setup |=> pready)
      else $error("short op stalled");
   chk_long_op: assert property (cmd_wr && long_op ##1 setup |=> !pready ##1 pready)
      else $error("long op timing");
   cover property (cmd_wr && long_op);
   cover property (pslverr);
   cover property (done && paddr == OFS_IOCMD);
endmodule
bind alu_core alu_core_checker i_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ---- alu_io.sv ----
// Purpose: I/O address translation and bit access on the low I/O range.
// Assumes: one command per start pulse; result registered one edge later.
// Notes:   only the bit-addressable range is modelled as storage.
module alu_io
   import alu_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire alu_io_cmd_t cmd,
   output alu_io_res_t      res,
   output logic             illegal
);

   logic [7:0]  mem [IO_BIT_REGS];
   logic        is_io_insn;
   logic        is_data;
   logic        is_bit_op;
   logic        legal;
   logic [7:0]  io_index;
   logic [8:0]  daddr;
   logic        in_bit_range;
   logic [7:0]  cur;
   logic        cur_bit;
   logic        writes;
   logic [7:0]  wdata;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   assign is_io_insn   = (cmd.kind == IO_IN) || (cmd.kind == IO_OUT);
   assign is_data      = (cmd.kind == IO_LOAD_DIRECT_DATA) || (cmd.kind == IO_STORE_DIRECT_DATA);
   assign is_bit_op    = !is_io_insn && !is_data;
   // dedicated I/O forms stop at the top of the 64-entry space
   // extended space above it is reached by load/store only
   assign legal        = is_io_insn ? (cmd.addr <= IO_LAST)
                       : is_data    ? (cmd.addr >= IO_DATA_OFS)
                       :              (cmd.addr <= IO_BIT_LAST);
   assign io_index     = is_data ? cmd.addr - IO_DATA_OFS : cmd.addr;
   assign daddr        = is_data ? {1'b0, cmd.addr} : {1'b0, cmd.addr} + {1'b0, IO_DATA_OFS};
   assign in_bit_range = legal && (io_index <= IO_BIT_LAST);
   assign cur          = in_bit_range ? mem[io_index[4:0]] : 8'h00;
   assign cur_bit      = cur[cmd.bitsel];

   // bit ops touch only the named bit, so write-one flags nearby survive
   always_comb
   begin
      wdata  = cur;
      writes = 1'b0;
      unique case (cmd.kind)
         IO_OUT, IO_STORE_DIRECT_DATA:
         begin
            wdata  = cmd.data;
            writes = 1'b1;
         end
         IO_SET_IO_BIT:
         begin
            wdata[cmd.bitsel] = 1'b1;
            writes = 1'b1;
         end
         IO_CLEAR_IO_BIT:
         begin
            wdata[cmd.bitsel] = 1'b0;
            writes = 1'b1;
         end
         IO_IN, IO_LOAD_DIRECT_DATA, IO_SKIP_IF_IO_BIT_SET, IO_SKIP_IF_IO_BIT_CLEAR:
         begin
            writes = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // storage and result
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (start && writes && in_bit_range)
      begin
         mem[io_index[4:0]] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         res     <= '0;
         illegal <= 1'b0;
      end
      else
      begin
         illegal <= start && !legal;
         if (start)
         begin
            res.daddr <= daddr;
            res.legal <= legal;
            res.rdata <= cur;
            res.skip  <= legal && is_bit_op
                      && (((cmd.kind == IO_SKIP_IF_IO_BIT_SET) && cur_bit)
                       || ((cmd.kind == IO_SKIP_IF_IO_BIT_CLEAR) && !cur_bit));
         end
      end
   end

endmodule

// ---- alu_mul.sv ----
// Purpose: 8x8 multiplier with signed, mixed and fractional forms.
// Assumes: combinational; the caller registers the result.
// Notes:   carry is taken from the unshifted product.
module alu_mul
   import alu_pkg::*;
(
   input  wire logic [7:0]  a,
   input  wire logic [7:0]  b,
   input  wire alu_op_t     op,
   output logic      [15:0] product,
   output logic             carry
);

   logic               sign_a;
   logic               sign_b;
   logic               frac;
   logic signed [8:0]  ext_a;
   logic signed [8:0]  ext_b;
   logic signed [17:0] full;
   logic        [15:0] raw;

   // ------------------------------------------------------------
   // operand extension
   // ------------------------------------------------------------
   assign sign_a = (op == OP_MULTIPLY_SIGNED) || (op == OP_MULTIPLY_SIGNED_BY_UNSIGNED)
                || (op == OP_FRACTIONAL_MULTIPLY_SIGNED) || (op == OP_FRACTIONAL_MULTIPLY_MIXED);
   assign sign_b = (op == OP_MULTIPLY_SIGNED) || (op == OP_FRACTIONAL_MULTIPLY_SIGNED);
   assign frac   = (op == OP_FRACTIONAL_MULTIPLY_UNSIGNED) || (op == OP_FRACTIONAL_MULTIPLY_SIGNED)
                || (op == OP_FRACTIONAL_MULTIPLY_MIXED);
   assign ext_a  = $signed({sign_a & a[7], a});
   assign ext_b  = $signed({sign_b & b[7], b});
   assign full   = ext_a * ext_b;
   assign raw    = full[15:0];

   // ------------------------------------------------------------
   // fractional forms shift the product left by one
   // ------------------------------------------------------------
   assign product = frac ? {raw[14:0], 1'b0} : raw;
   assign carry   = raw[15];

endmodule

// ---- alu_pkg.sv ----
// Purpose: shared constants and types of the execution unit.
// Assumes: byte registers, 32-bit APB word per register.
// Notes:   field positions and offsets live here only.
package alu_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  OFS_OPA    = 8'h00;
   localparam logic [7:0]  OFS_OPB    = 8'h04;
   localparam logic [7:0]  OFS_OPH    = 8'h08;
   localparam logic [7:0]  OFS_CMD    = 8'h0c;
   localparam logic [7:0]  OFS_RES    = 8'h10;
   localparam logic [7:0]  OFS_SREG   = 8'h14;
   localparam logic [7:0]  OFS_IOCMD  = 8'h18;
   localparam logic [7:0]  OFS_IORES  = 8'h1c;
   localparam logic [7:0]  OFS_EVT    = 8'h20;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int          CMD_OP_LSB    = 0;
   localparam int          SREG_BUSY_BIT = 8;
   localparam int          IOC_ADDR_LSB  = 0;
   localparam int          IOC_BIT_LSB   = 8;
   localparam int          IOC_KIND_LSB  = 12;
   localparam int          IOC_DATA_LSB  = 16;
   localparam int          IOR_DADDR_LSB = 0;
   localparam int          IOR_LEGAL_BIT = 9;
   localparam int          IOR_SKIP_BIT  = 10;
   localparam int          IOR_RDATA_LSB = 16;
   localparam int          EVT_ILLEGAL   = 0;
   localparam int          EVT_W         = 1;
   localparam logic [5:0]  SREG_RESET    = 6'h00;

   // ------------------------------------------------------------
   // address space limits and operation constants
   // ------------------------------------------------------------
   localparam logic [7:0]  IO_BIT_LAST  = 8'h1f;
   localparam logic [7:0]  IO_LAST      = 8'h3f;
   localparam logic [7:0]  IO_DATA_OFS  = 8'h20;
   localparam logic [7:0]  EXT_FIRST    = 8'h60;
   localparam int          IO_BIT_REGS  = 32;
   localparam logic [7:0]  ALL_ONES     = 8'hff;
   localparam logic [7:0]  BYTE_MIN_NEG = 8'h80;
   localparam logic [7:0]  BYTE_MAX_POS = 8'h7f;
   localparam int          CYC_SHORT    = 1;
   localparam int          CYC_LONG     = 2;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT, OP_SUBTRACT_WITH_CARRY,
      OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_IMMEDIATE_WITH_CARRY,
      OP_ADD_IMMEDIATE_WORD, OP_SUBTRACT_IMMEDIATE_WORD,
      OP_AND, OP_AND_WITH_CONSTANT, OP_OR, OP_OR_WITH_CONSTANT,
      OP_EXCLUSIVE_OR_REGISTERS, OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT_NEGATE,
      OP_SET_BITS_IN_REGISTER, OP_CLEAR_BITS_IN_REGISTER, OP_INCREMENT,
      OP_DECREMENT, OP_TEST_ZERO_OR_MINUS, OP_CLEAR_REGISTER,
      OP_SET_REGISTER_ALL_ONES, OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED,
      OP_MULTIPLY_SIGNED_BY_UNSIGNED, OP_FRACTIONAL_MULTIPLY_UNSIGNED,
      OP_FRACTIONAL_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_MIXED
   } alu_op_t;

   typedef enum logic [2:0] {
      IO_IN, IO_OUT, IO_LOAD_DIRECT_DATA, IO_STORE_DIRECT_DATA,
      IO_SET_IO_BIT, IO_CLEAR_IO_BIT, IO_SKIP_IF_IO_BIT_SET, IO_SKIP_IF_IO_BIT_CLEAR
   } alu_io_kind_t;

   typedef enum logic {ST_IDLE = 1'b0, ST_SECOND = 1'b1} alu_state_t;

   typedef struct packed {
      logic h;
      logic s;
      logic v;
      logic n;
      logic z;
      logic c;
   } alu_flags_t;

   typedef struct packed {
      alu_io_kind_t kind;
      logic [2:0]   bitsel;
      logic [7:0]   addr;
      logic [7:0]   data;
   } alu_io_cmd_t;

   typedef struct packed {
      logic [8:0] daddr;
      logic       legal;
      logic       skip;
      logic [7:0] rdata;
   } alu_io_res_t;

endpackage

// ---- testbench.sv ----
// Purpose: self-checking bench for the execution unit
// Assumes: APB slave, waits only on pready
// Notes:   flag masks pick the flags checked, some of them left alone by the op
`define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench
   import alu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // stimulus and checks
   // ----
   logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err;
   int          num_errors = 0, samples_checked = 0;
   always #12.5 clk = ~clk;
   alu_core i_alu_core (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // request held until pready seen; unused bits written as zero
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
   endtask
   // entry: a, b, high byte, flags in, op, flags expected, flag mask, result
   task automatic op(input logic [71:0] e);
      apb(1'b1, OFS_OPA, {24'h0, e[71:64]});
      apb(1'b1, OFS_OPB, {24'h0, e[63:56]});
      apb(1'b1, OFS_OPH, {24'h0, e[55:48]});
      apb(1'b1, OFS_SREG, {24'h0, e[47:40]});
      apb(1'b1, OFS_CMD, {24'h0, e[39:32]});
      apb(1'b0, OFS_RES, 32'h0);
      `CMP(rd[15:0], e[15:0])
      apb(1'b0, OFS_SREG, 32'h0);
      `CMP(rd[7:0] & e[23:16], e[31:24])
   endtask
   // entry: command, expected status, mask
   task automatic io(input logic [95:0] e);
      apb(1'b1, OFS_IOCMD, e[95:64]);
      apb(1'b0, OFS_IORES, 32'h0);
      `CMP(rd & e[31:0], e[63:32])
   endtask
   task automatic t_map;
      apb(1'b0, OFS_SREG, 32'h0);
      `CMP(rd, {26'h0, SREG_RESET})
      apb(1'b1, OFS_RES, 32'h1234);
      apb(1'b0, OFS_RES, 32'h0);
      `CMP(rd, 32'h0)
      `CMP(err, 1'b0)
      apb(1'b0, 8'h24, 32'h0);
      `CMP(rd, 32'h0)
      `CMP(err, 1'b1)
      $display("map done");
   endtask
   task automatic t_arith;
      logic [71:0] v [8] = '{72'h7f01000000_2c2f_0080, 72'hff00000101_232f_0000, 72'h0001000002_252f_00ff,
         72'h0504000303_022f_0000, 72'h8001000004_282f_007f, 72'h100f000105_202f_0000,
         72'hff017f0006_0c1f_8000, 72'h0001000007_151f_ffff};
      foreach (v[i])
         op(v[i]);
      $display("arith done");
   endtask
   task automatic t_mul;
      logic [71:0] v [6] = '{72'hffff000016_0103_fe01, 72'h8080000017_0003_4000, 72'hff02000018_0103_fffe,
         72'h8080000019_0003_8000, 72'hc04000001a_0103_e000, 72'h800000001b_0203_0000};
      foreach (v[i])
         op(v[i]);
      $display("mul done");
   endtask
   task automatic t_logic;
      logic [71:0] v [14] = '{72'hf08f003f08_353f_0080, 72'h0ff0003f09_333f_0000, 72'h800100000a_043f_0081,
         72'h000000000b_023f_0000, 72'h5555003f0c_333f_0000, 72'h0f0000000d_050f_00f0,
         72'h010000000e_252f_00ff, 72'h018000000f_043f_0081, 72'hff7f000010_043f_0080,
         72'h7f00000011_0c0f_0080, 72'h8000000112_090f_007f, 72'h8000003f13_353f_0080,
         72'h5a00003f14_333f_0000, 72'h0000002a15_2a3f_00ff};
      foreach (v[i])
         op(v[i]);
      $display("logic done");
   endtask
   task automatic t_io;
      logic [95:0] v [13] = '{96'h005a1005_00000225_000007ff, 96'h00004005_00000225_000007ff,
         96'h00005605_00000225_000007ff, 96'h00000005_001b0225_00ff07ff, 96'h00006305_00000625_000007ff,
         96'h00007205_00000625_000007ff, 96'h00773025_00000225_000007ff, 96'h00000005_00770225_00ff07ff,
         96'h00006305_00000225_000007ff, 96'h0000003f_0000025f_000007ff, 96'h00002060_00000260_000007ff,
         96'h00000060_00000000_00000600,
         96'h00004020_00000000_00000600};
      foreach (v[i])
         io(v[i]);
      apb(1'b0, OFS_EVT, 32'h0);
      `CMP(rd, 32'h1)
      apb(1'b1, OFS_EVT, 32'h1);
      apb(1'b0, OFS_EVT, 32'h0);
      `CMP(rd, 32'h0)
      $display("io done");
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_map;
      t_arith;
      t_mul;
      t_logic;
      t_io;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      tally_and_finish;
   end
   // run needs about 500 cycles
   initial
   begin
      repeat (8000) @(posedge clk);
      num_errors++;
      tally_and_finish;
   end
endmodule
